// ### include/config_word_loader_pkg.sv
package config_word_loader_pkg;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [23:0] CONFIG_SPACE_BASE = 24'hF80000;
  localparam logic [23:0] CONFIG_SPACE_LOW  = 24'h800000;
  localparam logic [23:0] WORD_ONE_ADDR     = 24'h00ABFE;
  localparam logic [23:0] WORD_STEP         = 24'h000002;
  localparam int          WORD_COUNT        = 2;
  localparam int          CONFIG_SLOTS      = 5;

  // ---------------------------------------------------------------
  // word one field layout and reset values
  // ---------------------------------------------------------------
  localparam int          UPPER_BYTE_LSB    = 16;
  localparam int          RESERVED15_POS    = 15;
  localparam int          SCAN_EN_POS       = 14;
  localparam int          CODE_PROT_POS     = 13;
  localparam int          WRITE_PROT_POS    = 12;
  localparam int          DEBUG_POS         = 11;
  localparam int          EMU_SEL_LSB       = 8;
  localparam int          WDT_EN_POS        = 7;
  localparam int          WIN_DIS_POS       = 6;
  localparam int          UNIMPL5_POS       = 5;
  localparam int          PRESCALE_POS      = 4;
  localparam int          POSTSCALE_LSB     = 0;
  localparam logic [23:0] WORD_ONE_FORCE1   = 24'hFF0020;
  localparam logic [23:0] WORD_RESET        = 24'hFFFFFF;
  localparam logic [1:0]  EMU_RESERVED      = 2'h0;
  localparam logic [3:0]  FLASH_LATENCY     = 4'h2;

  typedef struct packed {
    logic       boundary_scan_port_enable;
    logic       code_protect_on;
    logic       write_protect_on;
    logic       reset_into_debug;
    logic [2:0] emulator_pin_pair;
    logic       emulator_pin_reserved;
    logic       watchdog_on;
    logic       watchdog_windowed;
    logic       watchdog_prescale_select;
    logic [3:0] watchdog_postscale_select;
  } options_t;

  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } flash_req_t;

endpackage

// ### verilog/config_field_decoder.sv
`timescale 1ns/1ns
module config_field_decoder (
  input  wire logic [23:0]                        i_word,
  output config_word_loader_pkg::options_t         o_options
);

  // -------------------------------------------------------------
  // field decode of word one
  // -------------------------------------------------------------
  wire logic [1:0] emu_sel = i_word[config_word_loader_pkg::EMU_SEL_LSB +: 2];
  wire logic       wdt_on  = i_word[config_word_loader_pkg::WDT_EN_POS];

  // programmed bit reads 0, unprogrammed 1 [R1]
  assign o_options.boundary_scan_port_enable = i_word[config_word_loader_pkg::SCAN_EN_POS];   // [R10]
  assign o_options.code_protect_on  = ~i_word[config_word_loader_pkg::CODE_PROT_POS];         // [R11]
  assign o_options.write_protect_on = ~i_word[config_word_loader_pkg::WRITE_PROT_POS];        // [R12]
  assign o_options.reset_into_debug = ~i_word[config_word_loader_pkg::DEBUG_POS];             // [R13]
  // one-hot pair: bit0 pair one (11), bit1 pair two (10), bit2 pair three (01)
  assign o_options.emulator_pin_pair = {emu_sel == 2'h1, emu_sel == 2'h2, emu_sel == 2'h3};   // [R14]
  assign o_options.emulator_pin_reserved = (emu_sel == config_word_loader_pkg::EMU_RESERVED); // [R14]
  assign o_options.watchdog_on = wdt_on;                                                      // [R15]
  // windowed only when the watchdog itself is on
  assign o_options.watchdog_windowed = wdt_on & ~i_word[config_word_loader_pkg::WIN_DIS_POS]; // [R16]
  assign o_options.watchdog_prescale_select = i_word[config_word_loader_pkg::PRESCALE_POS];   // [R17]
  // divide ratio is 2 to the field value
  assign o_options.watchdog_postscale_select = i_word[config_word_loader_pkg::POSTSCALE_LSB +: 4]; // [R18]

endmodule

// ### verilog/config_word_loader.sv
`timescale 1ns/1ns
// Function
// (R1) programmed bit reads 0, unprogrammed 1
// (R2) configuration space only via table access
// (R3) configuration storage volatile, reloaded after power-up
// (R4) fetch top two flash words
// (R5) unpack words into five configuration slots
// (R6) reload on every kind of reset
// (R7) upper bytes written ones, no effect
// (R8) word one bits 23-16, 5 read one
// (R9) programmer keeps bit 15 at one
// (R10) bit 14 enables boundary scan port
// (R11) bit 13 zero protects all code
// (R12) bit 12 zero blocks program writes
// (R13) bit 11 zero resets into debug
// (R14) bits 9-8 pick emulator pin pair
// (R15) bit 7 enables watchdog
// (R16) bit 6 zero selects windowed watchdog
// (R17) bit 4 selects watchdog prescaler
// (R18) bits 3-0 postscale two to n
// (R19) tools keep code off configuration words
// (R20) core held in reset until loaded
module config_word_loader (
  input  wire logic                                 i_clock,
  input  wire logic                                 i_arst_n,
  input  wire logic                                 i_device_reset,
  output config_word_loader_pkg::flash_req_t         o_flash_req,
  input  wire logic                                 i_flash_valid,
  input  wire logic [23:0]                          i_flash_data,
  input  wire logic                                 i_table_read,
  input  wire logic [23:0]                          i_table_addr,
  output logic      [23:0]                          o_table_data,
  output logic                                      o_table_hit,
  output logic                                      o_core_reset,
  output logic                                      o_config_loaded,
  output config_word_loader_pkg::options_t           o_options
);

  typedef enum logic [1:0] {LOAD_IDLE, LOAD_ASK, LOAD_WAIT, LOAD_DONE} load_state_t;

  // -------------------------------------------------------------
  // reset pin synchroniser
  // -------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  // two flops before any reader
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= i_device_reset;
      rst_sync <= rst_meta;
    end
  end

  // -------------------------------------------------------------
  // load sequencer
  // -------------------------------------------------------------
  load_state_t state;
  load_state_t next_state;
  logic        word_idx;
  logic        next_word_idx;
  logic [23:0] cfg_slot [config_word_loader_pkg::CONFIG_SLOTS];

  wire logic        last_word = (word_idx == 1'(config_word_loader_pkg::WORD_COUNT - 1));
  // word one at the top, word two one step below [R4]
  wire logic [23:0] fetch_addr = word_idx ? config_word_loader_pkg::WORD_ONE_ADDR
                                          - config_word_loader_pkg::WORD_STEP
                                          : config_word_loader_pkg::WORD_ONE_ADDR; // [R4]
  wire logic        take_word = (state == LOAD_WAIT) && i_flash_valid;

  // any synchronised reset restarts the load [R6]
  always_comb begin
    next_state    = state;
    next_word_idx = word_idx;
    unique case (state)
      LOAD_IDLE: next_state = LOAD_ASK;
      LOAD_ASK:  next_state = LOAD_WAIT;
      LOAD_WAIT: begin
        if (i_flash_valid) begin
          next_state    = last_word ? LOAD_DONE : LOAD_ASK;
          next_word_idx = ~word_idx;
        end
      end
      LOAD_DONE: next_state = LOAD_DONE;
    endcase
    if (rst_sync) begin
      next_state    = LOAD_IDLE; // [R6]
      next_word_idx = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state    <= LOAD_IDLE;
      word_idx <= 1'b0;
    end else begin
      state    <= next_state;
      word_idx <= next_word_idx;
    end
  end

  // flash read request
  assign o_flash_req.req  = (state == LOAD_ASK);
  assign o_flash_req.addr = fetch_addr;

  // -------------------------------------------------------------
  // volatile configuration slots
  // -------------------------------------------------------------
  // slot 0 word one, slot 1 word two, slots 2..4 further full copies of word one [R5]
  wire logic [23:0] word_one_in = i_flash_data | config_word_loader_pkg::WORD_ONE_FORCE1; // [R8] [R7]
  wire logic [23:0] word_two_in = i_flash_data | {8'hFF, 16'h0000}; // [R7]

  // slots are flops only; lost at power-down, set to all ones by the asynchronous reset [R3]
  genvar g;
  generate
    for (g = 0; g < config_word_loader_pkg::CONFIG_SLOTS; g++) begin : gen_slot
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          cfg_slot[g] <= config_word_loader_pkg::WORD_RESET; // [R1]
        end else if (take_word) begin
          if (g == 1 && word_idx) begin
            cfg_slot[g] <= word_two_in; // [R5]
          end else if (g != 1 && !word_idx) begin
            cfg_slot[g] <= word_one_in; // [R5]
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // table read port into configuration space
  // -------------------------------------------------------------
  function automatic logic [2:0] slot_of(input logic [23:0] addr);
    slot_of = 3'((addr - config_word_loader_pkg::CONFIG_SPACE_BASE) >> 1);
  endfunction

  // only table reads reach this space, from the base upward [R2]
  wire logic [2:0] table_slot = slot_of(i_table_addr);
  wire logic       table_in_space = (i_table_addr >= config_word_loader_pkg::CONFIG_SPACE_LOW); // [R2]
  // full-width offset check, so a far address cannot wrap onto a slot index
  wire logic [23:0] table_offset = i_table_addr - config_word_loader_pkg::CONFIG_SPACE_BASE;
  wire logic       table_mapped = (i_table_addr >= config_word_loader_pkg::CONFIG_SPACE_BASE)
                                  && (table_offset < 24'(2 * config_word_loader_pkg::CONFIG_SLOTS))
                                  && !i_table_addr[0];

  // registered table answer, one cycle after the read
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_table_data <= 24'h000000;
      o_table_hit  <= 1'b0;
    end else begin
      o_table_hit  <= i_table_read && table_in_space && table_mapped; // [R2]
      o_table_data <= (i_table_read && table_in_space && table_mapped) ? cfg_slot[table_slot]
                                                                       : 24'hFFFFFF;
    end
  end

  // -------------------------------------------------------------
  // core reset hold and option outputs
  // -------------------------------------------------------------
  // core stays in reset until both words are in [R20]
  assign o_core_reset    = (state != LOAD_DONE); // [R20]
  assign o_config_loaded = (state == LOAD_DONE);

  config_field_decoder u_decode (
    .i_word    (cfg_slot[0]),
    .o_options (o_options)
  );

endmodule

// ### tb/config_word_loader_monitor.sv
`timescale 1ns/1ns
module config_word_loader_monitor (
  input wire logic                          i_clock,
  input wire logic                          i_arst_n,
  input config_word_loader_pkg::flash_req_t o_flash_req,
  input wire logic                          i_table_read,
  input wire logic [23:0]                   i_table_addr,
  input wire logic [23:0]                   o_table_data,
  input wire logic                          o_table_hit,
  input wire logic                          o_core_reset,
  input wire logic                          o_config_loaded,
  input config_word_loader_pkg::options_t   o_options
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------
  // load, table read and option decode checks
  // ----------------------------
  a_loaded_inverse: assert property (o_config_loaded == !o_core_reset)
    else $error("loaded flag wrong");
  a_req_while_held: assert property (o_flash_req.req |-> o_core_reset)
    else $error("fetch with core running");
  a_req_one_cycle: assert property (o_flash_req.req |=> !o_flash_req.req)
    else $error("fetch request too long");
  a_req_top_words: assert property (o_flash_req.req |-> o_flash_req.addr inside {24'h00ABFE, 24'h00ABFC})
    else $error("fetch address wrong");
  a_refused_read: assert property (i_table_read && (i_table_addr[23:19] != 5'h1F || i_table_addr[0]
    || i_table_addr > 24'hF80008) |=> !o_table_hit && o_table_data == 24'hFFFFFF)
    else $error("unmapped read answered");
  a_slot_hit: assert property (i_table_read && i_table_addr == 24'hF80000 |=> o_table_hit)
    else $error("slot read missed");
  a_unimpl_ones: assert property (i_table_read && i_table_addr == 24'hF80000
    |=> o_table_data[23:16] == 8'hFF && o_table_data[5])
    else $error("unimplemented bits not one");
  a_windowed_wdt: assert property (o_options.watchdog_windowed |-> o_options.watchdog_on)
    else $error("window without watchdog");
  a_emu_onehot: assert property ($onehot({o_options.emulator_pin_pair, o_options.emulator_pin_reserved}))
    else $error("pin pair decode wrong");
  c_table_hit: cover property (o_table_hit);
  c_reload: cover property ($rose(o_config_loaded));
  c_windowed: cover property (o_options.watchdog_windowed);
endmodule
bind config_word_loader config_word_loader_monitor i_config_word_loader_monitor (.i_clock(i_clock),
  .i_arst_n(i_arst_n), .o_flash_req(o_flash_req), .i_table_read(i_table_read), .i_table_addr(i_table_addr),
  .o_table_data(o_table_data), .o_table_hit(o_table_hit), .o_core_reset(o_core_reset),
  .o_config_loaded(o_config_loaded), .o_options(o_options));

// ### tb/flash_word_store.sv
`timescale 1ns/1ns
module flash_word_store (
  input wire logic                          i_clock,
  input wire logic                          i_arst_n,
  input config_word_loader_pkg::flash_req_t i_req,
  input wire logic [3:0]                    i_delay,
  input wire logic [23:0]                   i_word_one,
  input wire logic [23:0]                   i_word_two,
  output logic                              o_valid,
  output logic [23:0]                       o_data
);
  logic [3:0]  wait_count;
  logic        busy;
  logic [23:0] word;
  // answer i_delay+2 cycles after the request; bus shows inverse data when idle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
      o_valid <= 1'b0;
      o_data <= 24'h5A5A5A;
    end else if (i_req.req) begin
      busy <= 1'b1;
      wait_count <= i_delay;
      word <= (i_req.addr == 24'h00ABFE) ? i_word_one : i_word_two;
    end else if (busy && wait_count == 4'h0) begin
      busy <= 1'b0;
      o_valid <= 1'b1;
      o_data <= word;
    end else begin
      wait_count <= wait_count - 4'h1;
      o_valid <= 1'b0;
      o_data <= ~o_data;
    end
  end
endmodule

// ### tb/config_word_loader_tb_top.sv
`timescale 1ns/1ns
module config_word_loader_tb_top;
  logic        i_clock = 0;
  logic        i_arst_n = 0;
  logic        dev_rst = 0;
  logic        table_read = 0;
  logic [23:0] table_addr = 24'h000000;
  logic [23:0] word_one = 24'hFFFFFF;
  logic [23:0] word_two = 24'hFFFFFF;
  logic [3:0]  delay = 4'h0;
  logic [23:0] flash_data, table_data, rd;
  logic        flash_valid, table_hit, core_reset, loaded, hit;
  logic [23:0] w1s[4] = '{24'hFFFFFF, 24'hFF8000, 24'hFFAE9F, 24'hFFFD4A};
  logic [23:0] w2s[4] = '{24'hFFFFFF, 24'hFF1234, 24'hFF00C3, 24'hFFA5A5};
  logic [3:0]  dls[4] = '{4'h0, 4'h5, 4'h1, 4'h3};
  logic [23:0] refused[5] = '{24'h00ABFE, 24'h7FFFFE, 24'hF80001, 24'hF8000A, 24'hF80010};
  config_word_loader_pkg::flash_req_t flash_req;
  config_word_loader_pkg::options_t   options;
  int          bad_count = 0;
  int          checked = 0;
  always #5 i_clock = ~i_clock;
  config_word_loader i_config_word_loader (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_device_reset(dev_rst),
    .o_flash_req(flash_req), .i_flash_valid(flash_valid), .i_flash_data(flash_data), .i_table_read(table_read),
    .i_table_addr(table_addr), .o_table_data(table_data), .o_table_hit(table_hit), .o_core_reset(core_reset),
    .o_config_loaded(loaded), .o_options(options));
  flash_word_store i_flash_word_store (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_req(flash_req),
    .i_delay(delay), .i_word_one(word_one), .i_word_two(word_two), .o_valid(flash_valid), .o_data(flash_data));
  // ----------------------------
  // helpers
  // ----------------------------
  function automatic logic [23:0] decode(input logic [23:0] w);
    return {9'h000, w[14], ~w[13], ~w[12], ~w[11], w[9:8] == 2'h1, w[9:8] == 2'h2, w[9:8] == 2'h3,
            w[9:8] == 2'h0, w[7], w[7] & ~w[6], w[4], w[3:0]};
  endfunction
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (exp !== got) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_for(input logic level);
    for (int n = 0; loaded !== level; n++) begin
      if (n == 200) begin
        check("loaded", 24'(level), 24'(loaded));
        finish_test();
      end
      @(negedge i_clock);
    end
  endtask
  task automatic table_rd(input logic [23:0] addr);
    @(negedge i_clock);
    table_read = 1;
    table_addr = addr;
    @(negedge i_clock);
    table_read = 0;
    rd = table_data;
    hit = table_hit;
  endtask
  // main sequence: each word pair loaded through a device reset
  initial begin
    repeat (8) @(negedge i_clock);
    check("reset options", decode(24'hFFFFFF), 24'(options));
    check("core held", 24'h000001, 24'(core_reset));
    i_arst_n = 1;
    wait_for(1'b1);
    for (int v = 0; v < 4; v++) begin
      word_one = w1s[v];
      word_two = w2s[v];
      delay = dls[v];
      dev_rst = 1;
      @(negedge i_clock);
      dev_rst = 0;
      wait_for(1'b0);
      wait_for(1'b1);
      check("options", decode(w1s[v]), 24'(options));
      table_rd(24'hF80000);
      check("word one slot", w1s[v] | 24'hFF0020, rd);
      table_rd(24'hF80002);
      check("word two slot", w2s[v] | 24'hFF0000, rd);
    end
    foreach (refused[i]) begin
      table_rd(refused[i]);
      check("refused data", 24'hFFFFFF, rd);
      check("refused hit", 24'h000000, 24'(hit));
    end
    table_rd(24'hF80008);
    check("last slot hit", 24'h000001, 24'(hit));
    i_arst_n = 0;
    @(negedge i_clock);
    check("lost options", decode(24'hFFFFFF), 24'(options));
    i_arst_n = 1;
    wait_for(1'b1);
    check("reloaded", decode(w1s[3]), 24'(options));
    finish_test();
  end
endmodule
